//--- timer_b_channel_capture_compare_tb_top.sv
// self-checking bench of the timer channel capture/compare block
`timescale 1ns/1ns
`include "tmrb_defines.vh"
module timer_b_channel_capture_compare_tb_top;
    localparam c0 = `TMRB_IDX_CTRL0;
    localparam v0h = `TMRB_IDX_VAL0_HI;
    localparam v0l = `TMRB_IDX_VAL0_LO;
    localparam st = `TMRB_IDX_IRQ_STAT;
    localparam mk = `TMRB_IDX_IRQ_MASK;
    reg clk, sys_rst, avs_read, avs_write, cnt_overflow;
    reg [7:0] avs_address, rdata;
    reg [31:0] avs_writedata;
    reg [15:0] cnt_value;
    reg [1:0] ext_level, code;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, irq;
    wire [1:0] pin_in, pin_out, pin_oe;
    wire [7:0] pins = {3'h0, irq, pin_oe, pin_out};
    integer mismatches, num_checks;
    tmrb_chan_cc DUT (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cnt_value(cnt_value),
        .cnt_overflow(cnt_overflow), .channel_pin_in(pin_in),
        .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .irq(irq));
    tmrb_pin_model u_pin (.clk(clk), .ext_level(ext_level),
        .channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
        .channel_pin_in(pin_in));
    // free running bus clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task stop_test;
    begin
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    task chk(input [8*6:1] what, input [7:0] exp, input [7:0] got);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("wrong value %0s exp %h got %h", what, exp, got);
        end
    end
    endtask
    // one access held until waitrequest is seen low, then two idle edges
    // so that pins and flags moved by the access have settled
    task bus(input wr, input [7:0] adr, input [7:0] wd);
    begin
        avs_address <= adr;
        avs_writedata <= {24'h000000, wd};
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        rdata = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
        @(posedge clk);
    end
    endtask
    task rd(input [7:0] adr, input [7:0] exp);
    begin
        bus(1'b0, adr, 8'h00);
        chk("reg", exp, rdata);
    end
    endtask
    // one cycle of counter value and overflow, then time to settle
    task hit(input [15:0] v, input ov);
    begin
        cnt_value <= v;
        cnt_overflow <= ov;
        @(posedge clk);
        cnt_value <= 16'h0100;
        cnt_overflow <= 1'b0;
        repeat (4) @(posedge clk);
    end
    endtask
    // watchdog far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches = mismatches + 1;
        stop_test;
    end
    // main sequence
    initial
    begin
        mismatches = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h00000000;
        cnt_value = 16'h0100;
        cnt_overflow = 1'b0;
        ext_level = 2'h0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk("pins", 8'h03, pins);
        rd(c0, 8'h00);
        bus(1'b1, c0, 8'h10);
        chk("pins", 8'h02, pins);
        bus(1'b1, v0h, 8'h00);
        bus(1'b1, v0l, 8'h05);
        bus(1'b1, mk, 8'h01);
        bus(1'b1, c0, 8'h14);
        hit(16'h0005, 1'b0);
        chk("pins", 8'h17, pins);
        rd(c0, 8'h94);
        bus(1'b1, c0, 8'h14);
        rd(c0, 8'h14);
        bus(1'b1, st, 8'h01);
        chk("pins", 8'h07, pins);
        bus(1'b1, mk, 8'h00);
        hit(16'h0005, 1'b0);
        rd(st, 8'h01);
        bus(1'b1, mk, 8'h01);
        chk("pins", 8'h16, pins);
        bus(1'b1, st, 8'h01);
        bus(1'b1, mk, 8'h00);
        // set then clear action codes
        for (code = 2'h3; code >= 2'h2; code = code - 2'h1)
        begin
            bus(1'b1, c0, {4'h1, code, 2'h0});
            hit(16'h0005, 1'b0);
            chk("pins", 8'h06 | {7'h00, code[0]}, pins);
        end
        bus(1'b1, c0, 8'h1A);
        hit(16'h0005, 1'b1);
        chk("pins", 8'h07, pins);
        hit(16'h0100, 1'b1);
        chk("pins", 8'h06, pins);
        bus(1'b1, c0, 8'h19);
        hit(16'h0100, 1'b1);
        hit(16'h0005, 1'b0);
        chk("pins", 8'h07, pins);
        bus(1'b1, c0, 8'h18);
        hit(16'h0005, 1'b0);
        chk("pins", 8'h07, pins);
        hit(16'h0100, 1'b1);
        hit(16'h0005, 1'b0);
        chk("pins", 8'h06, pins);
        bus(1'b1, c0, 8'h14);
        bus(1'b1, v0h, 8'h00);
        hit(16'h0005, 1'b0);
        chk("pins", 8'h06, pins);
        bus(1'b1, v0l, 8'h05);
        hit(16'h0005, 1'b0);
        chk("pins", 8'h07, pins);
        bus(1'b1, c0, 8'h20);
        bus(1'b1, `TMRB_IDX_CTRL1, 8'h14);
        rd(`TMRB_IDX_CTRL1, 8'h00);
        bus(1'b1, c0, 8'h04);
        cnt_value <= 16'h1234;
        ext_level <= 2'h1;
        repeat (8) @(posedge clk);
        rd(v0h, 8'h12);
        rd(v0l, 8'h34);
        cnt_value <= 16'h5678;
        rd(v0h, 8'h12);
        ext_level <= 2'h0;
        repeat (8) @(posedge clk);
        ext_level <= 2'h1;
        repeat (8) @(posedge clk);
        rd(v0l, 8'h34);
        bus(1'b1, c0, 8'h08);
        ext_level <= 2'h0;
        repeat (8) @(posedge clk);
        rd(v0h, 8'h56);
        rd(v0l, 8'h78);
        // capture on either edge
        bus(1'b1, c0, 8'h0C);
        cnt_value <= 16'h9ABC;
        ext_level <= 2'h1;
        repeat (8) @(posedge clk);
        rd(v0h, 8'h9A);
        rd(v0l, 8'hBC);
        cnt_value <= 16'h0100;
        // buffered compare: channel 1 value takes over at an overflow
        bus(1'b1, c0, 8'h24);
        bus(1'b1, v0h, 8'h00);
        bus(1'b1, v0l, 8'h05);
        hit(16'h0005, 1'b0);
        chk("pins", 8'h06, pins);
        bus(1'b1, `TMRB_IDX_VAL1_HI, 8'h00);
        bus(1'b1, `TMRB_IDX_VAL1_LO, 8'h09);
        hit(16'h0009, 1'b0);
        chk("pins", 8'h06, pins);
        hit(16'h0100, 1'b1);
        hit(16'h0009, 1'b0);
        chk("pins", 8'h07, pins);
        rd(8'h70, 8'h00);
        stop_test;
    end
endmodule // timer_b_channel_capture_compare_tb_top

//--- tmrb_chan_cc.v
// two-channel capture/compare/pwm logic with avalon-mm register slave
`timescale 1ns/1ns
`include "tmrb_defines.vh"

module tmrb_chan_cc (
    input wire clk,
    input wire sys_rst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire [15:0] cnt_value,
    input wire cnt_overflow,
    input wire [1:0] channel_pin_in,
    output reg [1:0] channel_pin_out,
    output reg [1:0] channel_pin_oe,
    output reg irq
);

// control bits per channel, flag kept separately
reg [6:0] ctrl_reg [0:1];
reg [15:0] val_reg [0:1];
reg [1:0] channel_event_flag_reg;
reg [1:0] flag_armed_reg;
reg [1:0] cap_lock_reg;
reg [1:0] cmp_lock_reg;
reg [1:0] max_eff_reg;
reg [1:0] pin_prev_reg;
reg [1:0] irq_stat_reg;
reg [1:0] irq_mask_reg;
reg buf_active_reg;
reg buf_pending_reg;
wire [1:0] pin_sync;

// channel mode decodes
function [1:0] els_of;
    input [6:0] c;
    begin
        els_of = {c[`TMRB_B_ELSH], c[`TMRB_B_ELSL]};
    end
endfunction

function is_capture;
    input [6:0] c;
    begin
        is_capture = (els_of(c) != `TMRB_ELS_OFF) &&
            !c[`TMRB_B_BUF] && !c[`TMRB_B_MSA];
    end
endfunction

function is_compare;
    input [6:0] c;
    begin
        is_compare = (els_of(c) != `TMRB_ELS_OFF) &&
            (c[`TMRB_B_BUF] || c[`TMRB_B_MSA]);
    end
endfunction

// output level after a match for the selected action
function match_level;
    input [1:0] els;
    input cur;
    begin
        case (els)
            `TMRB_ELS_TOGGLE: match_level = ~cur;
            `TMRB_ELS_CLEAR: match_level = 1'b0;
            `TMRB_ELS_SET: match_level = 1'b1;
            default: match_level = cur;
        endcase
    end
endfunction

tmrb_sync2 u_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(channel_pin_in),
    .sync_out(pin_sync)
);

// bus handshake: one wait cycle, answer at the second edge
wire bus_req = avs_read | avs_write;
wire do_wr = avs_write & ~avs_waitrequest & avs_byteenable[0];
// reads act at the edge that latches the data, so a flag set or a
// capture in the wait cycle is never armed or locked unseen
wire rd_take = avs_read & avs_waitrequest;
wire [7:0] wdat = avs_writedata[7:0];
wire [6:0] ctrl0 = ctrl_reg[0];
wire ch1_off = ctrl0[`TMRB_B_BUF];
wire [6:0] ctrl1 = ch1_off ? `TMRB_CTRL_RST : ctrl_reg[1];

// effective per-channel control after channel 1 gating
wire [6:0] ctl [0:1];
assign ctl[0] = ctrl0;
assign ctl[1] = ctrl1;

// compare value: buffered channel 0 uses the active buffer register
wire [15:0] cmp_val0 = (ctrl0[`TMRB_B_BUF] && buf_active_reg) ?
    val_reg[1] : val_reg[0];
wire [15:0] cmp_val [0:1];
assign cmp_val[0] = cmp_val0;
assign cmp_val[1] = val_reg[1];

// read data mux
reg [7:0] rd_mux;
always @*
begin
    rd_mux = 8'h00;
    case (avs_address)
        `TMRB_IDX_CTRL0:
            rd_mux = {channel_event_flag_reg[0], ctrl0};
        `TMRB_IDX_CTRL1:
            rd_mux = ch1_off ? 8'h00 :
                {channel_event_flag_reg[1], ctrl1};
        `TMRB_IDX_VAL0_HI: rd_mux = val_reg[0][15:8];
        `TMRB_IDX_VAL0_LO: rd_mux = val_reg[0][7:0];
        `TMRB_IDX_VAL1_HI: rd_mux = val_reg[1][15:8];
        `TMRB_IDX_VAL1_LO: rd_mux = val_reg[1][7:0];
        `TMRB_IDX_IRQ_STAT: rd_mux = {6'h00, irq_stat_reg};
        `TMRB_IDX_IRQ_MASK: rd_mux = {6'h00, irq_mask_reg};
        default: rd_mux = 8'h00;
    endcase
end

// bus slave registers; unmapped reads return zero
always @(posedge clk)
begin
    if (sys_rst)
    begin
        avs_waitrequest <= 1'b1;
        avs_readdata <= `TMRB_ZERO32;
    end
    else
    begin
        avs_waitrequest <= ~(bus_req & avs_waitrequest);
        if (rd_take)
            avs_readdata <= {24'h000000, rd_mux};
    end
end

// per-channel event detection
reg [1:0] cap_evt;
reg [1:0] cmp_evt;
reg [1:0] edge_hit;
always @*
begin : evt_detect
    // each process owns its loop index, so none is driven twice
    integer i;
    i = 0;
    cap_evt = 2'h0;
    cmp_evt = 2'h0;
    edge_hit = 2'h0;
    for (i = 0; i < 2; i = i + 1)
    begin
        case (els_of(ctl[i]))
            `TMRB_ELS_TOGGLE:
                edge_hit[i] = pin_sync[i] & ~pin_prev_reg[i];
            `TMRB_ELS_CLEAR:
                edge_hit[i] = ~pin_sync[i] & pin_prev_reg[i];
            `TMRB_ELS_SET:
                edge_hit[i] = pin_sync[i] ^ pin_prev_reg[i];
            default: edge_hit[i] = 1'b0;
        endcase
        // an edge meeting the high-byte read that locks would split
        // the pair, so the lock already counts at that edge
        cap_evt[i] = is_capture(ctl[i]) & edge_hit[i] &
            ~cap_lock_reg[i] & ~(rd_take && avs_address == ((i == 0) ?
            `TMRB_IDX_VAL0_HI : `TMRB_IDX_VAL1_HI));
        cmp_evt[i] = is_compare(ctl[i]) & (cnt_value == cmp_val[i]) &
            ~cmp_lock_reg[i];
    end
    // channel 1 value acts as buffer, it does no compare of its own
    if (ch1_off)
        cmp_evt[1] = 1'b0;
end

wire [1:0] chan_evt = cap_evt | cmp_evt;

// value registers have no reset: their content is undefined until written
always @(posedge clk)
begin : val_write
    // loop index local to this process
    integer i;
    for (i = 0; i < 2; i = i + 1)
    begin
        if (do_wr && avs_address == ((i == 0) ? `TMRB_IDX_VAL0_HI :
            `TMRB_IDX_VAL1_HI))
            val_reg[i][15:8] <= wdat;
        if (do_wr && avs_address == ((i == 0) ? `TMRB_IDX_VAL0_LO :
            `TMRB_IDX_VAL1_LO))
            val_reg[i][7:0] <= wdat;
        // a capture overrides a software write in the same cycle
        if (cap_evt[i])
            val_reg[i] <= cnt_value;
    end
end

// control, flags, byte-access locks and pin state
always @(posedge clk)
begin : ctrl_update
    // loop index local to this process
    integer i;
    if (sys_rst)
    begin
        for (i = 0; i < 2; i = i + 1)
            ctrl_reg[i] <= `TMRB_CTRL_RST;
        channel_event_flag_reg <= 2'h0;
        flag_armed_reg <= 2'h0;
        cap_lock_reg <= 2'h0;
        cmp_lock_reg <= 2'h0;
        max_eff_reg <= 2'h0;
        pin_prev_reg <= 2'h0;
        channel_pin_out <= `TMRB_PIN_RST;
        channel_pin_oe <= 2'h0;
        buf_active_reg <= 1'b0;
        buf_pending_reg <= 1'b0;
    end
    else
    begin
        pin_prev_reg <= pin_sync;
        for (i = 0; i < 2; i = i + 1)
        begin
            // control write; channel 1 is frozen while buffered mode is on
            if (do_wr && i == 0 && avs_address == `TMRB_IDX_CTRL0)
                ctrl_reg[0] <= wdat[6:0];
            if (do_wr && i == 1 && avs_address == `TMRB_IDX_CTRL1 &&
                !ch1_off)
                ctrl_reg[1] <= {wdat[6], 1'b0, wdat[4:0]};
            // flag: read while set arms, write 0 clears; a new event wins
            if (rd_take && avs_address == ((i == 0) ? `TMRB_IDX_CTRL0 :
                `TMRB_IDX_CTRL1) && channel_event_flag_reg[i])
                flag_armed_reg[i] <= 1'b1;
            if (chan_evt[i])
            begin
                channel_event_flag_reg[i] <= 1'b1;
                flag_armed_reg[i] <= 1'b0;
            end
            else if (do_wr && avs_address == ((i == 0) ? `TMRB_IDX_CTRL0 :
                `TMRB_IDX_CTRL1))
            begin
                if (flag_armed_reg[i] && !wdat[`TMRB_B_FLAG])
                    channel_event_flag_reg[i] <= 1'b0;
                flag_armed_reg[i] <= 1'b0;
            end
            // high-byte read locks capture until the low byte is read
            if (rd_take && is_capture(ctl[i]) && avs_address ==
                ((i == 0) ? `TMRB_IDX_VAL0_HI : `TMRB_IDX_VAL1_HI))
                cap_lock_reg[i] <= 1'b1;
            else if (rd_take && avs_address ==
                ((i == 0) ? `TMRB_IDX_VAL0_LO : `TMRB_IDX_VAL1_LO))
                cap_lock_reg[i] <= 1'b0;
            // high-byte write locks compare until the low byte is written
            if (do_wr && !is_capture(ctl[i]) && avs_address ==
                ((i == 0) ? `TMRB_IDX_VAL0_HI : `TMRB_IDX_VAL1_HI))
                cmp_lock_reg[i] <= 1'b1;
            else if (do_wr && avs_address ==
                ((i == 0) ? `TMRB_IDX_VAL0_LO : `TMRB_IDX_VAL1_LO))
                cmp_lock_reg[i] <= 1'b0;
            // max-duty is sampled only at a period boundary
            if (cnt_overflow)
                max_eff_reg[i] <= ctl[i][`TMRB_B_MAX];
            // pin drive follows the enabled compare function
            channel_pin_oe[i] <= is_compare(ctl[i]);
            // output level
            if (els_of(ctl[i]) == `TMRB_ELS_OFF)
                channel_pin_out[i] <= ~ctl[i][`TMRB_B_MSA];
            else if (is_compare(ctl[i]))
            begin
                if (ctl[i][`TMRB_B_TOV] && cnt_overflow)
                    channel_pin_out[i] <= ~channel_pin_out[i];
                else if (!ctl[i][`TMRB_B_TOV] &&
                    (cnt_overflow ? ctl[i][`TMRB_B_MAX] : max_eff_reg[i]))
                    // full duty: hold the level a match would end, high except for the set action
                    channel_pin_out[i] <= els_of(ctl[i]) !=
                        `TMRB_ELS_SET;
                else if (cmp_evt[i])
                    channel_pin_out[i] <= match_level(els_of(ctl[i]),
                        channel_pin_out[i]);
            end
        end
        // buffered mode: a freshly written idle register takes over
        // at the next overflow so the change never lands mid-period
        if (ctrl0[`TMRB_B_BUF])
        begin
            if (do_wr && avs_address == (buf_active_reg ?
                `TMRB_IDX_VAL0_LO : `TMRB_IDX_VAL1_LO))
                buf_pending_reg <= 1'b1;
            if (cnt_overflow && buf_pending_reg)
            begin
                buf_active_reg <= ~buf_active_reg;
                buf_pending_reg <= 1'b0;
            end
        end
        else
        begin
            buf_active_reg <= 1'b0;
            buf_pending_reg <= 1'b0;
        end
    end
end

// interrupt status: sticky, write one to clear, set wins
always @(posedge clk)
begin
    if (sys_rst)
    begin
        irq_stat_reg <= 2'h0;
        irq_mask_reg <= `TMRB_MASK_RST;
        irq <= 1'b0;
    end
    else
    begin
        if (do_wr && avs_address == `TMRB_IDX_IRQ_MASK)
            irq_mask_reg <= wdat[1:0];
        if (do_wr && avs_address == `TMRB_IDX_IRQ_STAT)
            irq_stat_reg <= (irq_stat_reg & ~wdat[1:0]) | chan_evt;
        else
            irq_stat_reg <= irq_stat_reg | chan_evt;
        irq <= |(irq_stat_reg & irq_mask_reg);
    end
end

endmodule // tmrb_chan_cc

//--- tmrb_chan_cc_monitor.sv
// checker of bus handshake and pin behaviour for the timer channel block
`timescale 1ns/1ns
`include "tmrb_defines.vh"
module tmrb_chan_cc_monitor (
    input wire clk,
    input wire sys_rst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire [15:0] cnt_value,
    input wire cnt_overflow,
    input wire [1:0] channel_pin_in,
    input wire [1:0] channel_pin_out,
    input wire [1:0] channel_pin_oe,
    input wire irq
);
    reg [3:0] wr_age_reg;
    wire wr_done = avs_write && !avs_waitrequest;
    // cycles since the last accepted write; only software may move pin enables and undriven levels
    always @(posedge clk)
    begin
        if (sys_rst || wr_done)
            wr_age_reg <= 4'h0;
        else if (wr_age_reg != 4'hF)
            wr_age_reg <= wr_age_reg + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_WAIT_ANSWER: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest) else $error("bus not answered");
    AST_WAIT_PULSE: assert property (!avs_waitrequest |=>
        avs_waitrequest) else $error("waitrequest low too long");
    AST_WAIT_IDLE: assert property (!(avs_read || avs_write) &&
        avs_waitrequest |=> avs_waitrequest) else $error("answer unasked");
    AST_RDATA_UPPER: assert property (avs_read && !avs_waitrequest |->
        avs_readdata[31:8] == 24'h000000) else $error("upper data not zero");
    AST_UNMAPPED: assert property (avs_read && !avs_waitrequest &&
        avs_address > `TMRB_IDX_IRQ_MASK |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    AST_RESET_OUT: assert property ($fell(sys_rst) |-> avs_waitrequest &&
        channel_pin_out == 2'h3 && channel_pin_oe == 2'h0 && !irq)
        else $error("outputs not at reset level");
    AST_OE_CAUSE: assert property ($changed(channel_pin_oe) |->
        wr_age_reg <= 4'h3) else $error("enable moved without a write");
    AST_PRESET_HOLD: assert property (|((channel_pin_out ^
        $past(channel_pin_out)) & ~channel_pin_oe & ~$past(channel_pin_oe))
        |-> wr_age_reg <= 4'h3) else $error("undriven level moved alone");
    AST_IRQ_FALL: assert property ($fell(irq) |-> wr_age_reg <= 4'h3)
        else $error("interrupt dropped without a write");
endmodule // tmrb_chan_cc_monitor

bind tmrb_chan_cc tmrb_chan_cc_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cnt_value(cnt_value), .cnt_overflow(cnt_overflow),
    .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
    .channel_pin_oe(channel_pin_oe), .irq(irq));

//--- tmrb_defines.vh
// constants for the timer channel capture/compare block
`ifndef TMRB_DEFINES_VH
`define TMRB_DEFINES_VH

// register indices (word address on the bus, byte address is four times)
`define TMRB_IDX_CTRL0 8'h45
`define TMRB_IDX_VAL0_HI 8'h46
`define TMRB_IDX_VAL0_LO 8'h47
`define TMRB_IDX_CTRL1 8'h48
`define TMRB_IDX_VAL1_HI 8'h49
`define TMRB_IDX_VAL1_LO 8'h4A
`define TMRB_IDX_IRQ_STAT 8'h60
`define TMRB_IDX_IRQ_MASK 8'h61

// channel status/control bit positions
`define TMRB_B_FLAG 7
`define TMRB_B_IE 6
`define TMRB_B_BUF 5
`define TMRB_B_MSA 4
`define TMRB_B_ELSH 3
`define TMRB_B_ELSL 2
`define TMRB_B_TOV 1
`define TMRB_B_MAX 0

// edge/level select codes
`define TMRB_ELS_OFF 2'h0
`define TMRB_ELS_TOGGLE 2'h1
`define TMRB_ELS_CLEAR 2'h2
`define TMRB_ELS_SET 2'h3

// reset values
`define TMRB_CTRL_RST 7'h00
`define TMRB_MASK_RST 2'h0
`define TMRB_PIN_RST 2'h3
`define TMRB_ZERO32 32'h00000000

`endif

//--- tmrb_pin_model.sv
// outside source on the two timer channel pins
`timescale 1ns/1ns
module tmrb_pin_model (
    input wire clk,
    input wire [1:0] ext_level,
    input wire [1:0] channel_pin_out,
    input wire [1:0] channel_pin_oe,
    output wire [1:0] channel_pin_in
);
    reg [1:0] src_reg;
    // source moves only on the clock, one edge after the bench changes ext_level
    always @(posedge clk)
    begin
        src_reg <= ext_level;
    end
    // the channel owns the wire while it drives, else the outside source
    assign channel_pin_in = (channel_pin_oe & channel_pin_out) |
        (~channel_pin_oe & src_reg);
endmodule // tmrb_pin_model

//--- tmrb_sync2.v
// two flip-flop synchroniser for the channel pin inputs
`timescale 1ns/1ns
module tmrb_sync2 (
    input wire clk,
    input wire sys_rst,
    input wire [1:0] async_in,
    output reg [1:0] sync_out
);

reg [1:0] meta_reg;

// first stage is read only by the second stage
always @(posedge clk)
begin
    if (sys_rst)
    begin
        meta_reg <= 2'h0;
        sync_out <= 2'h0;
    end
    else
    begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
    end
end

endmodule // tmrb_sync2
